// ==== hw/smpg_pkg.sv ====
// Shared constants, enumerations and state layout of the motion profiler
package smpg_pkg;

    // Clock rate and profile update interval
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned TICK_US = 1000;
    localparam int unsigned TICK_CYCLES = TICK_US * CLK_MHZ;

    // Step phase accumulator wraps once per second of clock
    localparam logic [27:0] STEP_WRAP = 28'h773_5940;

    // Field widths
    localparam int unsigned SPD_W = 24;
    localparam int unsigned RATE_W = 20;
    localparam int unsigned STEP_W = 32;
    localparam int unsigned FRAC_W = 16;
    localparam int unsigned VFX_W = 40;

    // Rates are per millisecond; equations need per second squared
    localparam logic [11:0] MS_PER_S = 12'h3E8;
    // Twice the rate for constant ramps, the average rate for S ramps
    localparam logic [11:0] BRAKE_CONST = 12'h7D0;
    localparam logic [11:0] BRAKE_SCURVE = 12'h3E8;

    // Jerk scaling: step = rate * J * JERK_MUL >> JERK_SHIFT
    localparam logic [15:0] JERK_MAX = 16'h1388;
    localparam logic [16:0] JERK_MUL = 17'h1_4F8B;
    localparam int unsigned JERK_SHIFT = 17;

    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_START_SPEED = 8'h04;
    localparam logic [7:0] ADDR_PROG_SPEED = 8'h08;
    localparam logic [7:0] ADDR_ACCEL = 8'h0C;
    localparam logic [7:0] ADDR_DECEL = 8'h10;
    localparam logic [7:0] ADDR_JERK = 8'h14;
    localparam logic [7:0] ADDR_MOVE_STEPS = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_CUR_SPEED = 8'h20;
    localparam logic [7:0] ADDR_STEPS_DONE = 8'h24;

    // Control bit positions
    localparam int unsigned CTRL_START = 0;
    localparam int unsigned CTRL_ABORT = 1;

    typedef enum logic [1:0] {
        ST_IDLE, ST_ACCEL, ST_CRUISE, ST_DECEL
    } smpg_state_t;

    typedef enum logic [1:0] {
        SH_RISE, SH_HOLD, SH_FALL
    } smpg_shape_t;

    typedef struct packed {
        logic [SPD_W-1:0] cfg_vs;
        logic [SPD_W-1:0] cfg_vp;
        logic [RATE_W-1:0] cfg_acc;
        logic [RATE_W-1:0] cfg_dec;
        logic [15:0] cfg_jerk;
        logic [STEP_W-1:0] cfg_steps;
        smpg_state_t st;
        smpg_shape_t sh;
        logic [VFX_W-1:0] v_fx;
        logic [VFX_W-1:0] a_fx;
        logic [VFX_W-1:0] dv_up;
        logic [VFX_W-1:0] v_ref;
        logic [STEP_W-1:0] steps_left;
        logic [STEP_W-1:0] steps_done;
        logic [31:0] tick_cnt;
        logic [27:0] phase_acc;
        logic step;
        logic busy;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } smpg_regs_t;

endpackage

// ==== hw/smpg_top.sv ====
// Stepper motion profile generator with APB register access
//
// The implementer's own choices: the APB slave port and the placing of the registers.

module smpg_top #(
    parameter int unsigned TICK_CYCLES = smpg_pkg::TICK_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Motor power stage
    output logic step_out,
    output logic busy_out
);

    smpg_pkg::smpg_regs_t s_reg;
    smpg_pkg::smpg_regs_t s_next;

    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    always_comb begin
        logic [15:0] jerk_eff;
        logic s_on;
        logic [smpg_pkg::RATE_W-1:0] rate;
        logic [smpg_pkg::VFX_W-1:0] lim;
        logic [63:0] jprod;
        logic [smpg_pkg::VFX_W-1:0] jstep;
        logic [smpg_pkg::VFX_W-1:0] vs_fx;
        logic [smpg_pkg::VFX_W-1:0] vp_fx;
        logic [smpg_pkg::VFX_W-1:0] target;
        logic [smpg_pkg::VFX_W-1:0] dv_gone;
        logic [smpg_pkg::VFX_W-1:0] dv_left;
        logic [smpg_pkg::VFX_W-1:0] a_new;
        logic [smpg_pkg::VFX_W-1:0] v_new;
        logic [smpg_pkg::SPD_W-1:0] v_int;
        logic [63:0] brake_have;
        logic [63:0] brake_need;
        logic go_dec;
        logic tick;
        logic [27:0] pacc;
        logic mapped;
        logic [31:0] rdata;
        logic do_write;
        jerk_eff = '0;
        s_on = 1'b0;
        rate = '0;
        lim = '0;
        jprod = '0;
        jstep = '0;
        vs_fx = '0;
        vp_fx = '0;
        target = '0;
        dv_gone = '0;
        dv_left = '0;
        a_new = '0;
        v_new = '0;
        v_int = '0;
        brake_have = '0;
        brake_need = '0;
        go_dec = 1'b0;
        tick = 1'b0;
        pacc = '0;
        mapped = 1'b0;
        rdata = '0;
        do_write = 1'b0;

        s_next = s_reg;
        s_next.step = 1'b0;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;

        // Out-of-range jerk saturates rather than wrapping
        jerk_eff = (s_reg.cfg_jerk > smpg_pkg::JERK_MAX) ?
                   smpg_pkg::JERK_MAX : s_reg.cfg_jerk;
        s_on = (jerk_eff != '0);
        rate = (s_reg.st == smpg_pkg::ST_DECEL) ?
               s_reg.cfg_dec : s_reg.cfg_acc;
        lim = {4'h0, rate, 16'h0000};
        // Jerk per tick in speed-fraction units, never below one LSB
        jprod = 64'(rate) * 64'(jerk_eff) *
                64'(smpg_pkg::JERK_MUL);
        jstep = smpg_pkg::VFX_W'(jprod >> smpg_pkg::JERK_SHIFT);
        if (jstep == '0) begin
            jstep = smpg_pkg::VFX_W'(1);
        end
        vs_fx = {s_reg.cfg_vs, 16'h0000};
        vp_fx = {s_reg.cfg_vp, 16'h0000};
        target = (s_reg.st == smpg_pkg::ST_DECEL) ? vs_fx : vp_fx;
        dv_gone = (s_reg.v_fx > s_reg.v_ref) ?
                  s_reg.v_fx - s_reg.v_ref : s_reg.v_ref - s_reg.v_fx;
        dv_left = (target > s_reg.v_fx) ?
                  target - s_reg.v_fx : s_reg.v_fx - target;
        v_int = s_reg.v_fx[smpg_pkg::VFX_W-1:smpg_pkg::FRAC_W];

        // Stopping distance test kept free of division
        if (v_int > s_reg.cfg_vs) begin
            brake_have = 64'(v_int) * 64'(v_int) -
                         64'(s_reg.cfg_vs) * 64'(s_reg.cfg_vs);
        end
        brake_need = 64'(s_reg.steps_left) * 64'(s_reg.cfg_dec) *
                     64'(s_on ? smpg_pkg::BRAKE_SCURVE :
                                smpg_pkg::BRAKE_CONST);
        go_dec = (brake_need <= brake_have);
        tick = (s_reg.tick_cnt == TICK_LAST);

        if (s_reg.st != smpg_pkg::ST_IDLE) begin
            s_next.tick_cnt = tick ? '0 : s_reg.tick_cnt + 32'h0000_0001;

            pacc = s_reg.phase_acc + 28'(v_int);
            if (pacc >= smpg_pkg::STEP_WRAP &&
                s_reg.steps_left != '0) begin
                pacc = pacc - smpg_pkg::STEP_WRAP;
                s_next.step = 1'b1;
                s_next.steps_left = s_reg.steps_left - 32'h0000_0001;
                s_next.steps_done = s_reg.steps_done + 32'h0000_0001;
            end
            s_next.phase_acc = pacc;

            if (s_reg.steps_left == '0) begin
                s_next.st = smpg_pkg::ST_IDLE;
                s_next.busy = 1'b0;
                s_next.v_fx = '0;
                s_next.a_fx = '0;
            end else if (s_reg.st != smpg_pkg::ST_DECEL && go_dec) begin
                // Short moves leave the ramp early; long ones cruise
                s_next.st = smpg_pkg::ST_DECEL;
                s_next.sh = smpg_pkg::SH_RISE;
                s_next.v_ref = s_reg.v_fx;
                s_next.dv_up = '0;
                s_next.a_fx = s_on ? '0 :
                    {4'h0, s_reg.cfg_dec, 16'h0000};
            end else if (tick && (s_reg.st == smpg_pkg::ST_ACCEL ||
                         (s_reg.st == smpg_pkg::ST_DECEL &&
                          s_reg.v_fx > vs_fx))) begin
                a_new = s_reg.a_fx;
                if (!s_on) begin
                    a_new = lim;
                end else begin
                    case (s_reg.sh)
                        smpg_pkg::SH_RISE: begin
                            a_new = s_reg.a_fx + jstep;
                            s_next.dv_up = dv_gone;
                            if (a_new >= lim) begin
                                a_new = lim;
                                s_next.sh = smpg_pkg::SH_HOLD;
                            end
                            // Limit never hit: turn at the midpoint
                            if (dv_gone >= dv_left) begin
                                s_next.sh = smpg_pkg::SH_FALL;
                            end
                        end
                        smpg_pkg::SH_HOLD: begin
                            // Release as much speed as the rise took
                            if (dv_left <= s_reg.dv_up) begin
                                s_next.sh = smpg_pkg::SH_FALL;
                            end
                        end
                        smpg_pkg::SH_FALL: begin
                            // Floor keeps the ramp from stalling
                            if (s_reg.a_fx > jstep) begin
                                a_new = s_reg.a_fx - jstep;
                            end
                        end
                        default: begin
                            s_next.sh = smpg_pkg::SH_RISE;
                        end
                    endcase
                end
                s_next.a_fx = a_new;

                // One tick per millisecond adds the per-ms rate directly
                if (s_reg.st == smpg_pkg::ST_ACCEL) begin
                    v_new = s_reg.v_fx + a_new;
                    if (v_new >= vp_fx) begin
                        s_next.v_fx = vp_fx;
                        s_next.st = smpg_pkg::ST_CRUISE;
                        s_next.a_fx = '0;
                    end else begin
                        s_next.v_fx = v_new;
                    end
                end else begin
                    if (s_reg.v_fx <= vs_fx + a_new) begin
                        // Creep at start speed until the count runs out
                        s_next.v_fx = vs_fx;
                        s_next.a_fx = '0;
                    end else begin
                        s_next.v_fx = s_reg.v_fx - a_new;
                    end
                end
            end
        end

        // Register read mux and decode
        mapped = 1'b1;
        case (paddr)
            smpg_pkg::ADDR_CTRL: rdata = '0;
            smpg_pkg::ADDR_START_SPEED: rdata = 32'(s_reg.cfg_vs);
            smpg_pkg::ADDR_PROG_SPEED: rdata = 32'(s_reg.cfg_vp);
            smpg_pkg::ADDR_ACCEL: rdata = 32'(s_reg.cfg_acc);
            smpg_pkg::ADDR_DECEL: rdata = 32'(s_reg.cfg_dec);
            smpg_pkg::ADDR_JERK: rdata = 32'(s_reg.cfg_jerk);
            smpg_pkg::ADDR_MOVE_STEPS: rdata = s_reg.cfg_steps;
            smpg_pkg::ADDR_STATUS: rdata = 32'({s_reg.sh, s_reg.st,
                                                 s_reg.busy});
            smpg_pkg::ADDR_CUR_SPEED: rdata = 32'(v_int);
            smpg_pkg::ADDR_STEPS_DONE: rdata = s_reg.steps_done;
            default: begin
                rdata = '0;
                mapped = 1'b0;
            end
        endcase

        // One wait state: pready rises the cycle after access begins
        if (psel && penable && !s_reg.pready) begin
            s_next.pready = 1'b1;
            s_next.prdata = pwrite ? '0 : rdata;
            s_next.pslverr = !mapped;
        end
        do_write = psel && penable && s_reg.pready && pwrite && mapped;

        if (do_write) begin
            case (paddr)
                smpg_pkg::ADDR_START_SPEED:
                    s_next.cfg_vs = pwdata[smpg_pkg::SPD_W-1:0];
                smpg_pkg::ADDR_PROG_SPEED:
                    s_next.cfg_vp = pwdata[smpg_pkg::SPD_W-1:0];
                smpg_pkg::ADDR_ACCEL:
                    s_next.cfg_acc = pwdata[smpg_pkg::RATE_W-1:0];
                smpg_pkg::ADDR_DECEL:
                    s_next.cfg_dec = pwdata[smpg_pkg::RATE_W-1:0];
                smpg_pkg::ADDR_JERK:
                    s_next.cfg_jerk = pwdata[15:0];
                smpg_pkg::ADDR_MOVE_STEPS:
                    s_next.cfg_steps = pwdata;
                smpg_pkg::ADDR_CTRL: begin
                    if (pwdata[smpg_pkg::CTRL_ABORT]) begin
                        s_next.st = smpg_pkg::ST_IDLE;
                        s_next.busy = 1'b0;
                        s_next.v_fx = '0;
                        s_next.a_fx = '0;
                        s_next.step = 1'b0;
                    end else if (pwdata[smpg_pkg::CTRL_START] &&
                                 s_reg.st == smpg_pkg::ST_IDLE) begin
                        s_next.st = smpg_pkg::ST_ACCEL;
                        s_next.sh = smpg_pkg::SH_RISE;
                        s_next.busy = 1'b1;
                        s_next.v_fx = vs_fx;
                        s_next.v_ref = vs_fx;
                        s_next.dv_up = '0;
                        s_next.a_fx = s_on ? '0 : lim;
                        s_next.steps_left = s_reg.cfg_steps;
                        s_next.steps_done = '0;
                        s_next.tick_cnt = '0;
                        s_next.phase_acc = '0;
                    end
                end
                default: begin
                    s_next.cfg_steps = s_next.cfg_steps;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign step_out = s_reg.step;
    assign busy_out = s_reg.busy;

endmodule

// ==== test/smpg_host.sv ====
// Host model: APB master that loads move setups and polls status
module smpg_host (
    // Clock
    input wire logic pclk,
    // APB request
    output logic psel = 1'b0,
    output logic penable = 1'b0,
    output logic pwrite = 1'b0,
    output logic [7:0] paddr = 8'h00,
    output logic [31:0] pwdata = 32'h0000_0000,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    // Rates are handed over in per-millisecond units, unconverted
    task automatic xfer(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// ==== test/smpg_monitor.sv ====
// Port-level assertions for the motion profile generator
module smpg_monitor (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Motor power stage
    input wire logic step_out,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("ready late");
    property p_one; pready |=> !pready; endproperty
    a_one: assert property (p_one) else $error("ready too long");
    property p_cause; pready |-> $past(psel) && $past(penable); endproperty
    a_cause: assert property (p_cause) else $error("ready unasked");
    property p_unmapped;
        pready && paddr > 8'h24 |-> pslverr && (pwrite || prdata == 32'h0);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("no slave error");
    property p_mapped;
        pready && paddr <= 8'h24 && paddr[1:0] == 2'b00 |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("false slave error");
    property p_start;
        psel && penable && pready && pwrite && paddr == 8'h00
            && pwdata[1:0] == 2'b01 && !busy_out |=> busy_out;
    endproperty
    a_start: assert property (p_start) else $error("move not started");
    property p_step_busy; step_out |-> busy_out; endproperty
    a_step_busy: assert property (p_step_busy) else $error("idle step");
    // A 24-bit speed can never step faster than once per seven cycles
    property p_step_gap; step_out |=> !step_out [*6]; endproperty
    a_step_gap: assert property (p_step_gap) else $error("steps close");
endmodule

// ==== test/smpg_top_tb.sv ====
// Self-checking bench for the motion profile generator
module smpg_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] VS = 32'h000F_4240;
    localparam logic [31:0] VP = 32'h0010_C8E0;
    localparam logic [31:0] ACC = 32'h0000_2710;
    // Steepest braking keeps the start-speed creep short
    localparam logic [31:0] DEC = 32'h000F_FFFF;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, step_out, busy_out;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [31:0] pulses = 32'h0000_0000;
    int num_errors = 0;
    int checks = 0;

    always #4 pclk = ~pclk;
    always @(posedge pclk) if (step_out === 1'b1) pulses <= pulses + 32'h1;

    smpg_top #(.TICK_CYCLES(125)) smpg_top_inst (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .step_out, .busy_out);
    smpg_host smpg_host_inst (.pclk, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        smpg_host_inst.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] q,
        output logic e);
        smpg_host_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
    endtask

    // Seen: [0] cruise, [1] ramp speed off the rate grid, [2] S fall phase
    task automatic run(input logic [15:0] jrk, input logic [31:0] n,
        output logic [31:0] top, output logic [2:0] seen);
        logic [31:0] st, v, base;
        logic e;
        wr(smpg_pkg::ADDR_START_SPEED, VS);
        wr(smpg_pkg::ADDR_PROG_SPEED, VP);
        wr(smpg_pkg::ADDR_ACCEL, ACC);
        wr(smpg_pkg::ADDR_DECEL, DEC);
        wr(smpg_pkg::ADDR_JERK, {16'h0000, jrk});
        wr(smpg_pkg::ADDR_MOVE_STEPS, n);
        // Snapshot keeps the pulse counter on a single driver
        base = pulses;
        wr(smpg_pkg::ADDR_CTRL, 32'h0000_0001);
        top = VS;
        seen = 3'b000;
        for (int k = 0; k < 30000; k++) begin
            rd(smpg_pkg::ADDR_STATUS, st, e);
            if (st[0] !== 1'b1)
                break;
            rd(smpg_pkg::ADDR_CUR_SPEED, v, e);
            if (v > top)
                top = v;
            seen[0] |= (st[2:1] == 2'd2);
            seen[1] |= (st[2:1] == 2'd1 && (v - VS) % ACC != 0);
            seen[2] |= (st[4:3] == 2'd2);
        end
        chk(pulses - base, n);
    endtask

    task automatic t_regs();
        logic [31:0] q;
        logic e;
        rd(smpg_pkg::ADDR_PROG_SPEED, q, e);
        chk(q, 32'h0000_0000);
        wr(smpg_pkg::ADDR_ACCEL, 32'hFFFF_FFFF);
        rd(smpg_pkg::ADDR_ACCEL, q, e);
        chk(q, 32'h000F_FFFF);
        rd(8'h40, q, e);
        chk({q[30:0], e}, 32'h0000_0001);
        rd(smpg_pkg::ADDR_CTRL, q, e);
        chk({q[30:0], e}, 32'h0000_0000);
        // Start speed near the root of the rate in steps per second squared
        wr(smpg_pkg::ADDR_START_SPEED, 32'h0000_7E7E);
        rd(smpg_pkg::ADDR_START_SPEED, q, e);
        chk(q, 32'h0000_7E7E);
        // Zero decel rate sends the move straight to its start-speed creep; abort ends it
        wr(smpg_pkg::ADDR_MOVE_STEPS, 32'h0000_0064);
        wr(smpg_pkg::ADDR_CTRL, 32'h0000_0001);
        rd(smpg_pkg::ADDR_STATUS, q, e);
        chk({31'h0, q[0]}, 32'h0000_0001);
        wr(smpg_pkg::ADDR_CTRL, 32'h0000_0003);
        rd(smpg_pkg::ADDR_STATUS, q, e);
        chk(q, 32'h0000_0000);
        wr(smpg_pkg::ADDR_JERK, 32'hFFFF_FFFF);
        rd(smpg_pkg::ADDR_JERK, q, e);
        chk(q, 32'h0000_FFFF);
    endtask
    task automatic t_trap();
        logic [31:0] top;
        logic [2:0] seen;
        run(16'h0000, 32'h0000_00C8, top, seen);
        chk(top, VP);
        chk({29'h0, seen}, 32'h0000_0001);
    endtask
    task automatic t_tri();
        logic [31:0] top;
        logic [2:0] seen;
        run(16'h0000, 32'h0000_0032, top, seen);
        chk({29'h0, top < VP, top > VS, seen[0]}, 32'h0000_0006);
    endtask
    task automatic t_scurve();
        logic [31:0] top;
        logic [2:0] seen;
        run(16'h1388, 32'h0000_0096, top, seen);
        chk({29'h0, top <= VP, seen[2:1]}, 32'h0000_0007);
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (99000) @(posedge pclk);
        num_errors++;
        end_sim();
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_trap();
        t_tri();
        t_scurve();
        end_sim();
    end
endmodule

bind smpg_top smpg_monitor smpg_monitor_inst (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .step_out, .busy_out);
